// file: hdl/rml_cfg.svh
`ifndef RML_CFG_SVH
`define RML_CFG_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define RML_CTL_OFS    12'h880
`define RML_CNT_OFS    12'h88c

// ----------------------------------------
// control register field positions
// ----------------------------------------
`define RML_EN_BIT     0
`define RML_OVR_LSB    1
`define RML_OVR_MSB    4
`define RML_LIM_LSB    6
`define RML_LIM_MSB    15
`define RML_ADJ_LSB    16
`define RML_ADJ_MSB    31
`define RML_ADJ_SIGN   31

// ----------------------------------------
// reset values
// ----------------------------------------
`define RML_EN_RST     1'h0
`define RML_OVR_RST    4'h2
`define RML_LIM_RST    10'h010
`define RML_ADJ_RST    16'h0000
`define RML_CNT_RST    16'h0000

// ----------------------------------------
// estimate and counter constants
// ----------------------------------------
`define RML_CONST_EST  13'h0010
`define RML_DEC_UNIT   24'h000800
`define RML_FRAC_BITS  11
`define RML_RPT_LSB    8
`define RML_RCB_ROUND  12'h00f

`endif

// file: hdl/rml_pkg.sv
package rml_pkg;

   // metering state of the port
   typedef enum logic {
      RML_IDLE,
      RML_METER
   } rml_state_t;

   // fixed-point metering counter, 13.11
   typedef logic [23:0] rml_cnt_t;

endpackage

// file: hdl/rml_estimator.sv
`timescale 1ns/1ps
`include "rml_cfg.svh"

module rml_estimator
   import rml_pkg::*;
(
   // request description
   input  wire logic [9:0]  len_dw,
   input  wire logic [3:0]  addr_dw,
   input  wire logic        mem_rd,
   // settings
   input  wire logic [3:0]  ovr_factor,
   input  wire logic [9:0]  const_limit,
   // result
   output rml_cnt_t         est_init,
   output logic [10:0]      dw_need
);

   logic [10:0] len_full;
   logic [11:0] span;
   logic [7:0]  n_cpl;
   logic [3:0]  ovr_eff;
   logic [11:0] ovh;
   logic [12:0] est_calc;
   logic [12:0] est_sel;

   // a length field of zero means 1024 dwords
   assign len_full = (len_dw == 10'h000) ? 11'h400 : {1'b0, len_dw};
   assign dw_need  = len_full;

   // completions split on 64-byte boundaries (16 dwords)
   assign span  = {1'b0, len_full} + {8'h00, addr_dw} + `RML_RCB_ROUND;
   assign n_cpl = span[11:4];

   // overhead only charged on memory reads
   assign ovr_eff  = mem_rd ? ovr_factor : 4'h0;
   assign ovh      = {8'h00, ovr_eff} * {4'h0, n_cpl};
   assign est_calc = {2'h0, len_full} + {1'b0, ovh};

   // small reads take the fixed estimate
   assign est_sel = (len_full <= {1'b0, const_limit}) ? `RML_CONST_EST : est_calc;

   // integer estimate, all fraction bits zero
   assign est_init = {est_sel, {`RML_FRAC_BITS{1'b0}}};

endmodule

// file: hdl/rml_meter.sv
`timescale 1ns/1ps
`include "rml_cfg.svh"

module rml_meter
   import rml_pkg::*;
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // control
   input  wire logic     load,
   input  rml_cnt_t      load_val,
   input  wire logic     clear,
   input  rml_cnt_t      dec_amt,
   // state
   output rml_cnt_t      cnt
);

   rml_cnt_t cnt_ff;
   rml_cnt_t nxt_cnt;

   // load, clear or drain toward zero without wrapping
   always_comb begin
      nxt_cnt = cnt_ff;
      if (load) begin
         nxt_cnt = load_val;
      end else if (clear) begin
         nxt_cnt = '0;
      end else if (cnt_ff > dec_amt) begin
         nxt_cnt = cnt_ff - dec_amt;
      end else begin
         nxt_cnt = '0;
      end
   end

   // counter register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign cnt = cnt_ff;

endmodule

// file: hdl/rml_limiter.sv
`timescale 1ns/1ps
`include "rml_cfg.svh"

module rml_limiter
   import rml_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // register port
   input  wire logic [11:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // non-posted read requests
   input  wire logic        req_valid,
   input  wire logic        req_mem_rd,
   input  wire logic [9:0]  req_len_dw,
   input  wire logic [3:0]  req_addr_dw,
   output logic             req_ready
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic        ctl_en_ff;
   logic [3:0]  ctl_ovr_ff;
   logic [9:0]  ctl_lim_ff;
   logic [15:0] ctl_adj_ff;
   logic [15:0] count_ff;
   logic [31:0] rdata_ff;
   logic        ready_ff;
   rml_state_t  state_ff;

   logic        nxt_ctl_en;
   logic [3:0]  nxt_ctl_ovr;
   logic [9:0]  nxt_ctl_lim;
   logic [15:0] nxt_ctl_adj;
   logic [15:0] nxt_count;
   logic [31:0] nxt_rdata;
   logic        nxt_ready;
   rml_state_t  nxt_state;

   logic        accept;
   logic        load;
   logic        clear;
   rml_cnt_t    est_init;
   rml_cnt_t    dec_amt;
   rml_cnt_t    cnt_q;
   logic [10:0] dw_need;

   // ----------------------------------------
   // estimate and counter
   // ----------------------------------------

   // completion size estimate for the offered request
   rml_estimator u_est (
      .len_dw      (req_len_dw),
      .addr_dw     (req_addr_dw),
      .mem_rd      (req_mem_rd),
      .ovr_factor  (ctl_ovr_ff),
      .const_limit (ctl_lim_ff),
      .est_init    (est_init),
      .dw_need     (dw_need)
   );

   // one unit per tick plus the adjustment; sign bit is not used
   assign dec_amt = `RML_DEC_UNIT + {9'h000, ctl_adj_ff[14:0]};

   // 13.11 metering counter
   rml_meter u_meter (
      .mclk     (mclk),
      .rst      (rst),
      .load     (load),
      .load_val (est_init),
      .clear    (clear),
      .dec_amt  (dec_amt),
      .cnt      (cnt_q)
   );

   // ----------------------------------------
   // request gating
   // ----------------------------------------

   assign accept = req_valid & ready_ff;

   // load on a request accepted while enabled, release when drained or disabled
   always_comb begin
      nxt_state = state_ff;
      load      = 1'b0;
      clear     = 1'b0;
      unique case (state_ff)
         RML_IDLE: begin
            if (accept && ctl_en_ff) begin
               load      = 1'b1;
               nxt_state = RML_METER;
            end
         end
         RML_METER: begin
            if (!ctl_en_ff) begin
               clear     = 1'b1;
               nxt_state = RML_IDLE;
            end else if (cnt_q <= dec_amt) begin
               nxt_state = RML_IDLE;
            end
         end
      endcase
      nxt_ready = (nxt_state == RML_IDLE);
   end

   // state and ready registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_ff <= RML_IDLE;
         ready_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         ready_ff <= nxt_ready;
      end
   end

   assign req_ready = ready_ff;

   // ----------------------------------------
   // register file
   // ----------------------------------------

   // control writes; reserved bit 5 is dropped
   always_comb begin
      nxt_ctl_en  = ctl_en_ff;
      nxt_ctl_ovr = ctl_ovr_ff;
      nxt_ctl_lim = ctl_lim_ff;
      nxt_ctl_adj = ctl_adj_ff;
      if (reg_wr && reg_addr == `RML_CTL_OFS) begin
         nxt_ctl_en  = reg_wdata[`RML_EN_BIT];
         nxt_ctl_ovr = reg_wdata[`RML_OVR_MSB:`RML_OVR_LSB];
         nxt_ctl_lim = reg_wdata[`RML_LIM_MSB:`RML_LIM_LSB];
         nxt_ctl_adj = reg_wdata[`RML_ADJ_MSB:`RML_ADJ_LSB];
      end
   end

   // report the 13.3 view of every loaded initial value
   always_comb begin
      nxt_count = count_ff;
      if (load) begin
         nxt_count = est_init[23:`RML_RPT_LSB];
      end
   end

   // read data stands only in the cycle after the strobe
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (reg_rd) begin
         unique case (reg_addr)
            `RML_CTL_OFS: begin
               nxt_rdata = {ctl_adj_ff, ctl_lim_ff, 1'b0,
                            ctl_ovr_ff, ctl_en_ff};
            end
            `RML_CNT_OFS: begin
               nxt_rdata = {16'h0000, count_ff};
            end
            default: begin
               nxt_rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // register storage
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctl_en_ff  <= `RML_EN_RST;
         ctl_ovr_ff <= `RML_OVR_RST;
         ctl_lim_ff <= `RML_LIM_RST;
         ctl_adj_ff <= `RML_ADJ_RST;
         count_ff   <= `RML_CNT_RST;
         rdata_ff   <= 32'h0000_0000;
      end else begin
         ctl_en_ff  <= nxt_ctl_en;
         ctl_ovr_ff <= nxt_ctl_ovr;
         ctl_lim_ff <= nxt_ctl_lim;
         ctl_adj_ff <= nxt_ctl_adj;
         count_ff   <= nxt_count;
         rdata_ff   <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

   // ----------------------------------------
   // checks
   // ----------------------------------------

   // disabled port lets requests through untouched
   AST_NO_METER_OFF: assert property (
      @(posedge mclk) disable iff (rst)
      (accept && !ctl_en_ff) |=> (ready_ff && cnt_q == '0)
   ) else $error("request metered while disabled");

   // enabled accept loads the estimate and closes the gate
   AST_LOAD: assert property (
      @(posedge mclk) disable iff (rst)
      (accept && ctl_en_ff) |=> (cnt_q == $past(est_init)) && !ready_ff
   ) else $error("estimate not loaded on accepted request");

   // memory read overhead lifts estimate above raw length
   AST_OVERHEAD: assert property (
      @(posedge mclk) disable iff (rst)
      (req_valid && req_mem_rd && dw_need > {1'b0, ctl_lim_ff})
      |-> (est_init[23:11] >= {2'h0, dw_need} + {9'h000, ctl_ovr_ff})
   ) else $error("overhead factor not applied");

   // small reads get the constant estimate
   AST_CONST: assert property (
      @(posedge mclk) disable iff (rst)
      (req_valid && dw_need <= {1'b0, ctl_lim_ff})
      |-> (est_init[23:11] == `RML_CONST_EST)
   ) else $error("constant estimate not used");

   // large reads never fall below their length
   AST_CALC: assert property (
      @(posedge mclk) disable iff (rst)
      (req_valid && dw_need > {1'b0, ctl_lim_ff})
      |-> (est_init[23:11] >= {2'h0, dw_need})
   ) else $error("computed estimate too small");

   // counter falls by the exact decrement each cycle
   AST_DEC: assert property (
      @(posedge mclk) disable iff (rst)
      (state_ff == RML_METER && ctl_en_ff && cnt_q > dec_amt)
      |=> (cnt_q == $past(cnt_q) - $past(dec_amt))
   ) else $error("counter decrement wrong");

   // drain ends at zero and reopens the gate
   AST_SAT: assert property (
      @(posedge mclk) disable iff (rst)
      (state_ff == RML_METER && ctl_en_ff && cnt_q <= dec_amt)
      |=> (cnt_q == '0) && ready_ff
   ) else $error("counter did not saturate at zero");

   // gate stays closed while metering
   AST_HOLD: assert property (
      @(posedge mclk) disable iff (rst)
      (state_ff == RML_METER) |-> !ready_ff
   ) else $error("request accepted while metering");

   // report follows the load and its low fraction bits are zero
   AST_REPORT: assert property (
      @(posedge mclk) disable iff (rst)
      load |=> (count_ff == $past(est_init[23:8])) && ($past(est_init[7:0]) == 8'h00)
   ) else $error("initial count report wrong");

   // reserved control bit 5 reads as zero
   AST_RSVD: assert property (
      @(posedge mclk) disable iff (rst)
      (reg_rd && reg_addr == `RML_CTL_OFS) ##1 1'b1
      |-> (reg_rdata[5] == 1'b0)
   ) else $error("reserved control bit not zero");

   // read data only stands after a read strobe
   AST_RD_IDLE: assert property (
      @(posedge mclk) disable iff (rst)
      !reg_rd |=> (reg_rdata == 32'h0000_0000)
   ) else $error("read data outside read slot");

   // counter above zero always holds the gate closed
   AST_GATE_CNT: assert property (
      @(posedge mclk) disable iff (rst)
      (cnt_q != '0) |-> !ready_ff
   ) else $error("gate open while counter above zero");

   // counter rests at zero whenever no request is metered
   AST_IDLE_ZERO: assert property (
      @(posedge mclk) disable iff (rst)
      (state_ff == RML_IDLE) |-> (cnt_q == '0)
   ) else $error("counter not zero while idle");

   // dropping enable mid-drain clears the counter at once
   AST_ABORT: assert property (
      @(posedge mclk) disable iff (rst)
      (state_ff == RML_METER && !ctl_en_ff) |=> (cnt_q == '0) && ready_ff
   ) else $error("disable did not abort metering");

   // writes elsewhere leave every control field alone
   AST_CTL_KEEP: assert property (
      @(posedge mclk) disable iff (rst)
      !(reg_wr && reg_addr == `RML_CTL_OFS)
      |=> $stable(ctl_en_ff) && $stable(ctl_ovr_ff) && $stable(ctl_lim_ff) && $stable(ctl_adj_ff)
   ) else $error("control changed without a control write");

   // report changes only when a request is metered
   AST_COUNT_KEEP: assert property (
      @(posedge mclk) disable iff (rst)
      !load |=> $stable(count_ff)
   ) else $error("initial count changed without a load");

endmodule

// file: testbench/rml_requester.sv
`timescale 1ns/1ps

// ----------------------------------------
// link partner offering non-posted reads
// ----------------------------------------
module rml_requester (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // command from the bench
   input  wire logic       go,
   input  wire logic       go_mem,
   input  wire logic [9:0] go_len,
   input  wire logic [3:0] go_addr,
   // request lines toward the port
   input  wire logic       req_ready,
   output logic            req_valid,
   output logic            req_mem_rd,
   output logic [9:0]      req_len_dw,
   output logic [3:0]      req_addr_dw,
   output logic            taken
);
   // offer held until taken; released lines show inverted data
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         req_valid   <= 1'b0;
         req_mem_rd  <= 1'b0;
         req_len_dw  <= 10'h000;
         req_addr_dw <= 4'h0;
         taken       <= 1'b0;
      end else begin
         taken <= 1'b0;
         if (req_valid && req_ready) begin
            req_valid   <= 1'b0;
            taken       <= 1'b1;
            req_mem_rd  <= ~req_mem_rd;
            req_len_dw  <= ~req_len_dw;
            req_addr_dw <= ~req_addr_dw;
         end else if (!req_valid && go) begin
            req_valid   <= 1'b1;
            req_mem_rd  <= go_mem;
            req_len_dw  <= go_len;
            req_addr_dw <= go_addr;
         end
      end
   end
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`include "rml_cfg.svh"

module tb_top;
   // clock, reset and register port
   logic        mclk      = 1'b0;
   logic        rst       = 1'b1;
   logic [11:0] reg_addr  = 12'h000;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic [31:0] reg_rdata;
   // request lines
   logic        go        = 1'b0;
   logic        go_mem    = 1'b0;
   logic [9:0]  go_len    = 10'h000;
   logic [3:0]  go_addr   = 4'h0;
   logic        req_valid;
   logic        req_mem_rd;
   logic [9:0]  req_len_dw;
   logic [3:0]  req_addr_dw;
   logic        req_ready;
   logic        taken;
   // bookkeeping
   int          mismatches = 0;
   int          n_tests    = 0;
   int          seed       = 39;
   int          n;
   logic [31:0] d;
   logic [15:0] last_cnt = 16'h0;
   logic        en;
   logic [3:0]  ovr;
   logic [9:0]  lim;
   logic [15:0] adj;

   always #25 mclk = ~mclk;

   rml_limiter dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid), .req_mem_rd(req_mem_rd),
      .req_len_dw(req_len_dw), .req_addr_dw(req_addr_dw), .req_ready(req_ready));

   rml_requester partner (.mclk(mclk), .rst(rst), .go(go), .go_mem(go_mem), .go_len(go_len),
      .go_addr(go_addr), .req_ready(req_ready), .req_valid(req_valid), .req_mem_rd(req_mem_rd),
      .req_len_dw(req_len_dw), .req_addr_dw(req_addr_dw), .taken(taken));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task rd(input logic [11:0] a, output logic [31:0] v);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      v = reg_rdata;
   endtask

   // adjustment keeps its sign bit clear
   task cfg(input logic e, input logic [3:0] o, input logic [9:0] l, input logic [14:0] a);
      en  = e;
      ovr = o;
      lim = l;
      adj = {1'b0, a};
      wr(`RML_CTL_OFS, {adj, lim, 1'b0, ovr, en});
   endtask

   // estimate in whole dwords
   function automatic int exp_est(logic mem, logic [9:0] len, logic [3:0] ad);
      int need;
      need = (len == 10'h000) ? 1024 : int'(len);
      if (need <= int'(lim)) return 16;
      return need + (mem ? int'(ovr) : 0) * ((int'(ad) + need + 15) >> 4);
   endfunction

   // one request: gate length and reported initial count
   task req(input logic mem, input logic [9:0] len, input logic [3:0] ad);
      int est;
      int dec;
      int lowc;
      est  = exp_est(mem, len, ad);
      dec  = 32'h800 + int'(adj[14:0]);
      lowc = en ? ((est << 11) + dec - 1) / dec : 0;
      @(posedge mclk);
      go      <= 1'b1;
      go_mem  <= mem;
      go_len  <= len;
      go_addr <= ad;
      @(posedge mclk);
      go <= 1'b0;
      n = 0;
      while (taken !== 1'b1 && n < 100) begin
         @(negedge mclk);
         n++;
      end
      check(32'(taken), 32'h1);
      n = 0;
      while (req_ready !== 1'b1 && n < 5000) begin
         @(negedge mclk);
         n++;
      end
      check(32'(n), 32'(lowc));
      if (en) last_cnt = 16'(est << 3);
      rd(`RML_CNT_OFS, d);
      check(d, {16'h0, last_cnt});
      $display("test done: mem %0d len %0d gate %0d", mem, len, n);
   endtask

   task stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      rd(`RML_CTL_OFS, d);
      check(d, 32'h0000_0404);
      rd(`RML_CNT_OFS, d);
      check(d, 32'h0);
      wr(`RML_CTL_OFS, 32'h7fff_fffe);
      wr(`RML_CNT_OFS, 32'hffff_ffff);
      wr(12'h884, 32'hffff_ffff);
      rd(`RML_CTL_OFS, d);
      check(d, 32'h7fff_ffde);
      rd(`RML_CNT_OFS, d);
      check(d, 32'h0);
      rd(12'h884, d);
      check(d, 32'h0);
      $display("test done: registers");
      // hand-written corners: disabled, limit edge, io read, longest read
      cfg(1'b0, 4'h2, 10'h010, 15'h0);
      req(1'b1, 10'd200, 4'h0);
      cfg(1'b1, 4'h2, 10'h010, 15'h0);
      req(1'b1, 10'd16, 4'h0);
      req(1'b1, 10'd17, 4'h4);
      req(1'b0, 10'd17, 4'h4);
      req(1'b1, 10'd0, 4'hf);
      cfg(1'b1, 4'hf, 10'h000, 15'h7fff);
      req(1'b1, 10'd1, 4'h0);
      // random settings and requests
      repeat (12) begin
         cfg(1'b1, 4'($random(seed)), 10'($random(seed)) & 10'h03f, 15'($random(seed)));
         req(1'($random(seed)), 10'($random(seed)) & 10'h07f, 4'($random(seed)));
      end
      // metering aborted by clearing enable
      cfg(1'b1, 4'h2, 10'h010, 15'h0);
      @(posedge mclk);
      go     <= 1'b1;
      go_mem <= 1'b1;
      go_len <= 10'd0;
      @(posedge mclk);
      go <= 1'b0;
      repeat (6) @(negedge mclk);
      check(req_ready, 1'b0);
      cfg(1'b0, 4'h2, 10'h010, 15'h0);
      n = 0;
      while (req_ready !== 1'b1 && n < 3) begin
         @(negedge mclk);
         n++;
      end
      check(req_ready, 1'b1);
      cfg(1'b1, 4'h2, 10'h010, 15'h0);
      req(1'b1, 10'd4, 4'h0);
      $display("test done: abort");
      // mid-run reset while metering restores defaults and opens the gate
      cfg(1'b1, 4'h5, 10'h000, 15'h0);
      @(posedge mclk);
      go     <= 1'b1;
      go_len <= 10'd64;
      @(posedge mclk);
      go <= 1'b0;
      repeat (4) @(posedge mclk);
      rst <= 1'b1;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      check(req_ready, 1'b1);
      rd(`RML_CTL_OFS, d);
      check(d, 32'h0000_0404);
      rd(`RML_CNT_OFS, d);
      check(d, 32'h0);
      $display("test done: reset");
      stop_test;
   end

   // watchdog
   initial begin
      #(60000 * 50);
      mismatches++;
      $display("ERROR at %0t: watchdog expired", $time);
      stop_test;
   end
endmodule
